// [include/rtcfc_defs.vh]
/*
 * Constants for the fast correction scheduler and time registers.
 * Assumes a 20 MHz system clock and a one-second tick on the same clock.
 */
`ifndef RTCFC_DEFS_VH
`define RTCFC_DEFS_VH

// Register addresses
`define RTCFC_ADDR_SPARE    8'h03
`define RTCFC_ADDR_SECONDS  8'h04
`define RTCFC_ADDR_MINUTES  8'h05

// Reset values
`define RTCFC_SPARE_RST     8'h00
`define RTCFC_BCD_RST       7'h00
`define RTCFC_HALT_RST      1'b1

// Field positions
`define RTCFC_HALT_BIT      7
`define RTCFC_SIGN_BIT      6

// BCD limits
`define RTCFC_UNITS_MAX     4'h9
`define RTCFC_TENS_MAX      3'h5
`define RTCFC_SEC_LAST      6'h3b
`define RTCFC_FULL_SECONDS  7'h3c

// Timing: clock rate and pulse figures as fractions of a second
`define RTCFC_CLK_HZ        20000000
`define RTCFC_PULSE_DIV     1024
`define RTCFC_REPEAT_DIV    512

`endif

// [verilog/rtcfc_core.v]
/*
 * Fast (four-minute) correction scheduler, spare storage byte and the
 * seconds/minutes BCD registers with the clock-halt flag.
 * Assumes the serial interface decodes host accesses into the register
 * port, and that the one-second tick and offset bits come from logic on
 * i_clock; the oscillator status arrives from outside the clock domain.
 */
//
// Contract
// - Fast mode starts a correction cycle every four minutes, at most one pulse per second before second 59
// - Magnitudes above 60 put the extra pulses into second 59
// - Magnitude n up to 60 gives one pulse in seconds 00 to n-1
// - 61,62,63 give 2,3,4 pulses in second 59; -64 gives 5
// - Indication pulse lasts 1/1024 s, repeats every 1/512 s
// - Correction reaches timer sources below 1.024 kHz, not 4096 Hz
// - Clock outputs 32768 to 1024 Hz unaffected; 1 Hz output is corrected
// - Spare byte at 03h is read/write and resets to zero
// - Seconds at 04h in BCD, tens bits 6-4, units bits 3-0
// - Seconds bit 7 is clock-halt flag, set on oscillator stop, resets to 1
// - Oscillator counts as stopped until resonance is stable
// - Halt flag stays set until host clears it; clear fails while stopped
// - Minutes at 05h in BCD, bit 7 reads zero
// - Offset is seven-bit two's complement, +63 to -64 steps
// - Top bit of the offset register selects fast mode
// - Correction adds or removes internal pulses, never touches oscillator
// - Indication pulses reach the interrupt pin only when enabled
`timescale 1ns/100ps
`include "rtcfc_defs.vh"

module rtcfc_core #(
	parameter PULSE_CYC  = `RTCFC_CLK_HZ / `RTCFC_PULSE_DIV,
	parameter REPEAT_CYC = `RTCFC_CLK_HZ / `RTCFC_REPEAT_DIV
) (
	// Clock and reset
	input  wire       i_clock,
	input  wire       i_rst_n,
	// Register port from the serial interface
	input  wire [7:0] i_addr,
	input  wire       i_wr,
	input  wire [7:0] i_wdata,
	output reg  [7:0] o_rdata,
	// Offset register and control bits
	input  wire       i_fast_mode,
	input  wire [6:0] i_offset,
	input  wire       i_correction_irq_enable,
	// Timebase
	input  wire       i_tick_1hz,
	input  wire       i_osc_running,
	// Correction and carry outputs
	output reg        o_corr_pulse,
	output reg        o_corr_add,
	output reg        o_hour_carry,
	// Interrupt pin, open drain, active low
	output reg        o_int_n,
	output reg        o_int_oe
);

	reg  [1:0]  rst_sync_reg;
	wire        rst_n;
	reg  [1:0]  osc_sync_reg;
	wire        osc_ok;

	reg  [7:0]  spare_reg;
	reg         halt_reg;
	reg  [2:0]  sec_tens_reg;
	reg  [3:0]  sec_units_reg;
	reg  [2:0]  min_tens_reg;
	reg  [3:0]  min_units_reg;
	reg         corr_min_reg;
	reg  [2:0]  pend_reg;
	reg         busy_reg;
	reg  [31:0] cyc_reg;

	reg  [2:0]  sec_tens_next;
	reg  [3:0]  sec_units_next;
	reg  [2:0]  min_tens_next;
	reg  [3:0]  min_units_next;
	reg         sec_wrap;
	reg         min_wrap;

	wire [6:0]  magnitude;
	wire [6:0]  excess;
	wire [5:0]  sec_dec;
	wire [1:0]  min_mod4;
	wire        corr_start;
	reg  [2:0]  pulses_now;

	// Reset release through two flip-flops
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	// Oscillator status synchroniser
	always @(posedge i_clock or negedge rst_n) begin
		if (!rst_n)
			osc_sync_reg <= 2'h0;
		else
			osc_sync_reg <= {osc_sync_reg[0], i_osc_running};
	end
	assign osc_ok = osc_sync_reg[1];

	// BCD advance of seconds and minutes
	always @* begin
		sec_tens_next  = sec_tens_reg;
		sec_units_next = sec_units_reg + 4'h1;
		sec_wrap       = 1'b0;
		min_tens_next  = min_tens_reg;
		min_units_next = min_units_reg;
		min_wrap       = 1'b0;
		if (sec_units_reg >= `RTCFC_UNITS_MAX) begin
			sec_units_next = 4'h0;
			sec_tens_next  = sec_tens_reg + 3'h1;
			if (sec_tens_reg >= `RTCFC_TENS_MAX) begin
				sec_tens_next = 3'h0;
				sec_wrap      = 1'b1;
			end
		end
		if (sec_wrap) begin
			min_units_next = min_units_reg + 4'h1;
			if (min_units_reg >= `RTCFC_UNITS_MAX) begin
				min_units_next = 4'h0;
				min_tens_next  = min_tens_reg + 3'h1;
				if (min_tens_reg >= `RTCFC_TENS_MAX) begin
					min_tens_next = 3'h0;
					min_wrap      = 1'b1;
				end
			end
		end
	end

	// Offset magnitude from two's complement
	assign magnitude = i_offset[`RTCFC_SIGN_BIT] ?
		(7'h00 - i_offset) : i_offset;
	// Pulses due in second 59: magnitude minus 59, so 60..64 give 1..5
	assign excess = magnitude - {1'b0, `RTCFC_SEC_LAST};
	// Decimal value of the second being entered, and minute modulo four
	assign sec_dec = {sec_tens_next, 3'h0} + {2'h0, sec_tens_next, 1'b0} +
		{2'h0, sec_units_next};
	assign min_mod4 = min_tens_next[1:0] + min_tens_next[1:0] +
		min_units_next[1:0];
	assign corr_start = i_fast_mode && sec_wrap &&
		(min_mod4 == 2'h0);

	// Pulses due in the second being entered
	always @* begin
		pulses_now = 3'h0;
		if (sec_dec < `RTCFC_SEC_LAST) begin
			if ({1'b0, sec_dec} < magnitude)
				pulses_now = 3'h1;
		end else if (magnitude >= `RTCFC_FULL_SECONDS) begin
			// Usual pulse plus the excess beyond 60
			pulses_now = excess[2:0];
		end
	end

	// Register file and timekeeping
	always @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			spare_reg     <= `RTCFC_SPARE_RST;
			halt_reg      <= `RTCFC_HALT_RST;
			{sec_tens_reg, sec_units_reg} <= `RTCFC_BCD_RST;
			{min_tens_reg, min_units_reg} <= `RTCFC_BCD_RST;
			corr_min_reg  <= 1'b0;
			o_hour_carry  <= 1'b0;
		end else begin
			o_hour_carry <= i_tick_1hz & min_wrap;
			if (i_tick_1hz) begin
				sec_tens_reg  <= sec_tens_next;
				sec_units_reg <= sec_units_next;
				min_tens_reg  <= min_tens_next;
				min_units_reg <= min_units_next;
				if (sec_wrap)
					corr_min_reg <= corr_start;
			end
			if (i_wr && i_addr == `RTCFC_ADDR_SPARE)
				spare_reg <= i_wdata;
			if (i_wr && i_addr == `RTCFC_ADDR_SECONDS) begin
				sec_tens_reg  <= i_wdata[6:4];
				sec_units_reg <= i_wdata[3:0];
			end
			if (i_wr && i_addr == `RTCFC_ADDR_MINUTES) begin
				min_tens_reg  <= i_wdata[6:4];
				min_units_reg <= i_wdata[3:0];
			end
			// Stop condition wins over a host clear
			if (!osc_ok)
				halt_reg <= 1'b1;
			else if (i_wr && i_addr == `RTCFC_ADDR_SECONDS)
				halt_reg <= i_wdata[`RTCFC_HALT_BIT];
		end
	end

	// Read data
	always @(posedge i_clock or negedge rst_n) begin
		if (!rst_n)
			o_rdata <= 8'h00;
		else begin
			case (i_addr)
			`RTCFC_ADDR_SPARE:   o_rdata <= spare_reg;
			`RTCFC_ADDR_SECONDS: o_rdata <= {halt_reg, sec_tens_reg,
				sec_units_reg};
			`RTCFC_ADDR_MINUTES: o_rdata <= {1'b0, min_tens_reg,
				min_units_reg};
			default:             o_rdata <= 8'h00;
			endcase
		end
	end

	// Correction pulse train and interrupt indication
	always @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			pend_reg     <= 3'h0;
			busy_reg     <= 1'b0;
			cyc_reg      <= 32'h0;
			o_corr_pulse <= 1'b0;
			o_corr_add   <= 1'b0;
			o_int_n      <= 1'b1;
			o_int_oe     <= 1'b0;
		end else begin
			o_corr_pulse <= 1'b0;
			o_corr_add   <= ~i_offset[`RTCFC_SIGN_BIT];
			if (i_tick_1hz && i_fast_mode && (corr_start ||
				(corr_min_reg && !sec_wrap)))
				pend_reg <= pulses_now;
			else if (!busy_reg && pend_reg != 3'h0) begin
				// One internal pulse per indication pulse
				pend_reg     <= pend_reg - 3'h1;
				busy_reg     <= 1'b1;
				cyc_reg      <= 32'h0;
				o_corr_pulse <= 1'b1;
			end
			if (busy_reg) begin
				// The load cycle is part of the repeat period
				if (cyc_reg >= REPEAT_CYC - 2)
					busy_reg <= 1'b0;
				else
					cyc_reg <= cyc_reg + 32'h1;
			end
			o_int_oe <= i_correction_irq_enable && busy_reg &&
				(cyc_reg < PULSE_CYC);
			o_int_n  <= ~(i_correction_irq_enable && busy_reg &&
				(cyc_reg < PULSE_CYC));
		end
	end

endmodule

// [test/rtcfc_sva.sv]
/* Checker for the correction core ports.
   Assumes PULSE_CYC 8 and REPEAT_CYC 16. */
`timescale 1ns/100ps
module rtcfc_sva (
	// Clock, reset and inputs
	input wire       i_clock,
	input wire       i_rst_n,
	input wire [7:0] i_addr,
	input wire [6:0] i_offset,
	input wire       i_correction_irq_enable,
	input wire       i_tick_1hz,
	// Outputs
	input wire [7:0] o_rdata,
	input wire       o_corr_pulse,
	input wire       o_corr_add,
	input wire       o_hour_carry,
	input wire       o_int_n,
	input wire       o_int_oe
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	AST_PIN_OE: assert property (o_int_oe == !o_int_n)
		else $error("pin enable mismatch");
	AST_PULSE: assert property ($fell(o_int_n) |-> ##1
		(!o_int_n)[*7] ##1 o_int_n[*8]) else $error("pulse shape");
	AST_NO_IRQ: assert property (!$past(i_correction_irq_enable) |-> o_int_n)
		else $error("pin active while disabled");
	AST_INT_SRC: assert property ($fell(o_int_n) |-> $past(o_corr_pulse))
		else $error("pin pulse without correction");
	AST_CARRY: assert property (o_hour_carry |-> $past(i_tick_1hz)
		##1 !o_hour_carry) else $error("carry timing");
	AST_MIN_B7: assert property (i_addr == 8'h05 && $stable(i_addr)
		|-> !o_rdata[7]) else $error("minutes bit 7 set");
	AST_UNMAP: assert property ($stable(i_addr) &&
		(i_addr < 8'h03 || i_addr > 8'h05)
		|-> o_rdata == 8'h00) else $error("unmapped read");
	AST_ADD: assert property (o_corr_pulse && $stable(i_offset)
		|-> o_corr_add == !i_offset[6]) else $error("direction");
endmodule
bind rtcfc_core rtcfc_sva u_sva (.*);

// [test/rtcfc_host.sv]
/* Host model driving the register port.
   Assumes the core takes writes on the rising edge. */
`timescale 1ns/100ps
module rtcfc_host (
	// Clock and read data
	input  wire       i_clock,
	input  wire [7:0] i_rdata,
	// Register port
	output reg  [7:0] o_addr = 8'h00,
	output reg        o_wr = 1'b0,
	output reg  [7:0] o_wdata = 8'h00
);
	task wr(input [7:0] a, input [7:0] d);
		@(posedge i_clock);
		o_addr <= a;
		o_wr <= 1'b1;
		o_wdata <= d;
		@(posedge i_clock);
		o_wr <= 1'b0;
		o_wdata <= ~d;
	endtask
	// Reread after a clear tells if the oscillator runs
	task rd(input [7:0] a, output [7:0] d);
		@(posedge i_clock);
		o_addr <= a;
		repeat (2) @(posedge i_clock);
		#1 d = i_rdata;
	endtask
endmodule

// [test/rtcfc_core_test.sv]
/* Bench for the correction core.
   Assumes the host model and checker are compiled first. */
`timescale 1ns/100ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
	num_errors++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module rtcfc_core_test;
	reg        clock = 1'b0;
	reg        rst_n = 1'b0;
	reg        fast = 1'b0;
	reg  [6:0] offs = 7'h00;
	reg        irq_en = 1'b0;
	reg        tick = 1'b0;
	reg        osc = 1'b0;
	reg        int_q = 1'b1;
	reg  [7:0] d;
	wire [7:0] addr, wdata, rdata;
	wire       wr, pulse, carry, int_n;
	integer    num_errors = 0, cmp_count = 0, npul = 0, nint = 0, ncar = 0;
	integer    s, m, e, p, q;
	rtcfc_host u_host (.i_clock(clock), .i_rdata(rdata), .o_addr(addr),
		.o_wr(wr), .o_wdata(wdata));
	rtcfc_core #(.PULSE_CYC(8), .REPEAT_CYC(16)) u_dut (.i_clock(clock),
		.i_rst_n(rst_n), .i_addr(addr), .i_wr(wr), .i_wdata(wdata),
		.o_rdata(rdata), .i_fast_mode(fast), .i_offset(offs),
		.i_correction_irq_enable(irq_en), .i_tick_1hz(tick),
		.i_osc_running(osc), .o_corr_pulse(pulse), .o_corr_add(),
		.o_hour_carry(carry), .o_int_n(int_n), .o_int_oe());
	initial forever #25 clock = ~clock;
	always @(posedge clock) begin
		if (rst_n) begin
			npul <= npul + pulse;
			ncar <= ncar + carry;
			nint <= nint + (int_q & ~int_n);
			int_q <= int_n;
		end
	end
	task chk_rd(input [7:0] a, input [7:0] x);
		u_host.rd(a, d);
		`CHK("rdata", x, d)
	endtask
	task tick1;
		@(posedge clock);
		tick <= 1'b1;
		@(posedge clock);
		tick <= 1'b0;
		repeat (98) @(posedge clock);
	endtask
	task t_regs;
		chk_rd(8'h03, 8'h00);
		chk_rd(8'h04, 8'h80);
		u_host.wr(8'h03, 8'ha5);
		chk_rd(8'h03, 8'ha5);
		u_host.wr(8'h06, 8'h5a);
		chk_rd(8'h06, 8'h00);
		u_host.wr(8'h05, 8'hd9);
		chk_rd(8'h05, 8'h59);
	endtask
	task t_halt;
		u_host.wr(8'h04, 8'h59);
		chk_rd(8'h04, 8'hd9);
		osc <= 1'b1;
		repeat (2) @(posedge clock);
		u_host.wr(8'h04, 8'h59);
		chk_rd(8'h04, 8'h59);
		p = ncar;
		q = npul;
		tick1;
		`CHK("carry", 1, ncar - p)
		`CHK("nofast", 0, npul - q)
		chk_rd(8'h04, 8'h00);
		chk_rd(8'h05, 8'h00);
		osc <= 1'b0;
		repeat (2) @(posedge clock);
		chk_rd(8'h04, 8'h80);
		osc <= 1'b1;
	endtask
	task t_corr(input [6:0] o, input en);
		fast <= 1'b1;
		offs <= o;
		irq_en <= en;
		u_host.wr(8'h05, 8'h03);
		u_host.wr(8'h04, 8'h59);
		m = o[6] ? 128 - o : o;
		for (s = 0; s < 60; s++) begin
			e = (m <= 60) ? (s < m) : ((s < 59) ? 1 : m - 59);
			p = npul;
			q = nint;
			tick1;
			`CHK("pulses", e, npul - p)
			`CHK("pin", en ? e : 0, nint - q)
		end
	endtask
	task test_done;
		$display("Errors %0d, checks %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		t_regs;
		t_halt;
		t_corr(7'h02, 1'b1);
		t_corr(7'h3f, 1'b1);
		t_corr(7'h40, 1'b0);
		test_done;
	end
	initial begin
		repeat (25000) @(posedge clock);
		num_errors++;
		test_done;
	end
endmodule
